// ### hw/swid_pkg.sv
package swid_pkg;
    localparam int CNT_W = 17;
    localparam int CLK_PERIOD_NS = 8;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;

    // Line timing in ns, at the figures used by the slot engine, apart from POWERUP_WAIT_NS which nothing uses
    localparam int WR_SAMPLE_STD_NS = 30000;
    localparam int WR_SAMPLE_OD_NS = 3000;
    localparam int RD_HOLD_STD_NS = 30000;
    localparam int RD_HOLD_OD_NS = 3000;
    localparam int PRES_WAIT_STD_NS = 30000;
    localparam int PRES_WAIT_OD_NS = 3000;
    localparam int PRES_LOW_STD_NS = 120000;
    localparam int PRES_LOW_OD_NS = 16000;
    localparam int RST_DET_STD_NS = 240000;
    localparam int RST_DET_OD_NS = 48000;
    localparam int LONG_RST_NS = 480000;
    localparam int POWERUP_WAIT_NS = 1200000;

    // Cycle counts, least times rounded up
    localparam int WR_SAMPLE_STD_CYC = (WR_SAMPLE_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_SAMPLE_OD_CYC = (WR_SAMPLE_OD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_HOLD_STD_CYC = (RD_HOLD_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_HOLD_OD_CYC = (RD_HOLD_OD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRES_WAIT_STD_CYC = (PRES_WAIT_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRES_WAIT_OD_CYC = (PRES_WAIT_OD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRES_LOW_STD_CYC = (PRES_LOW_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRES_LOW_OD_CYC = (PRES_LOW_OD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_DET_STD_CYC = (RST_DET_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_DET_OD_CYC = (RST_DET_OD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LONG_RST_CYC = (LONG_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic LINE_RESET_VAL = 1'b1;
endpackage

// ### hw/swid_sync2.sv
`timescale 1ns/1ps
module swid_sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic d_in,
    output logic q_out
);
    logic meta_q;

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            meta_q <= RESET_VAL;
            q_out <= RESET_VAL;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule

// ### hw/swid_fifo.sv
`timescale 1ns/1ps
module swid_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign in_ready_out = (count_q != (AW+1)'(DEPTH));
    assign out_valid_out = (count_q != '0);
    assign out_data_out = mem_q[rptr_q];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wptr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            wptr_q <= '0;
            rptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ### hw/swid_slave.sv
`timescale 1ns/1ps
module swid_slave
    import swid_pkg::*;
#(
    parameter int unsigned RST_DET_STD = RST_DET_STD_CYC,
    parameter int unsigned RST_DET_OD = RST_DET_OD_CYC,
    parameter int unsigned LONG_RST = LONG_RST_CYC,
    parameter int unsigned PRES_LOW_STD = PRES_LOW_STD_CYC,
    parameter int FIFO_D = FIFO_DEPTH
) (
    input wire logic CORE_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic DQ_IN,
    output logic DQ_OUT,
    output logic DQ_OE_OUT,
    input wire logic FAST_SET_IN,
    input wire logic TX_VALID_IN,
    input wire logic [DATA_W-1:0] TX_DATA_IN,
    output logic TX_READY_OUT,
    output logic [DATA_W-1:0] RX_BYTE_OUT,
    output logic RX_VALID_OUT,
    output logic RESET_SEEN_OUT,
    output logic FAST_SPEED_FLAG_OUT
);
    typedef enum logic [2:0] {
        S_IDLE,
        S_WLOW,
        S_RDHOLD,
        S_RECOVER,
        S_RSTLOW,
        S_PWAIT,
        S_PLOW
    } state_t;

    state_t state_q;
    state_t state_d;
    logic line_s;
    logic [CNT_W-1:0] tmr_q;
    logic [CNT_W-1:0] tmr_d;
    logic [CNT_W-1:0] low_cnt_q;
    logic [CNT_W-1:0] low_cnt_d;
    logic [CNT_W-1:0] drive_len_q;
    logic fast_q;
    logic fast_d;
    logic oe_q;
    logic [DATA_W-1:0] tx_sh_q;
    logic [3:0] tx_cnt_q;
    logic [DATA_W-1:0] rx_sh_q;
    logic [2:0] rx_cnt_q;
    logic [DATA_W-1:0] rx_byte_q;
    logic rx_valid_q;
    logic rst_seen_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;

    logic [CNT_W-1:0] samp_last;
    logic [CNT_W-1:0] hold_last;
    logic [CNT_W-1:0] pwait_last;
    logic [CNT_W-1:0] plow_last;
    logic [CNT_W-1:0] rst_det;
    logic tx_act;
    logic tx_take;
    logic slot_fall;
    logic sample_now;
    logic rst_detect;
    logic long_rst;
    logic rx_full;
    logic [DATA_W-1:0] rx_sh_next;
    logic tx_push;

    swid_sync2 #(
        .RESET_VAL(LINE_RESET_VAL)
    ) u_line_sync (
        .clk_in(CORE_CLK_IN),
        .rst_b_in(RST_B_IN),
        .d_in(DQ_IN),
        .q_out(line_s)
    );

    swid_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_D)
    ) u_tx_fifo (
        .clk_in(CORE_CLK_IN),
        .rst_b_in(RST_B_IN),
        .in_valid_in(tx_push),
        .in_ready_out(fifo_in_ready),
        .in_data_in(TX_DATA_IN),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(tx_take),
        .out_data_out(fifo_out_data)
    );

    // Speed-dependent timing, fast set applies to every waveform but the long reset, whose LONG_RST threshold is the same at both speeds
    assign samp_last = fast_q ? CNT_W'(WR_SAMPLE_OD_CYC - 1) : CNT_W'(WR_SAMPLE_STD_CYC - 1);
    assign hold_last = fast_q ? CNT_W'(RD_HOLD_OD_CYC - 1) : CNT_W'(RD_HOLD_STD_CYC - 1);
    assign pwait_last = fast_q ? CNT_W'(PRES_WAIT_OD_CYC - 1) : CNT_W'(PRES_WAIT_STD_CYC - 1);
    assign plow_last = fast_q ? CNT_W'(PRES_LOW_OD_CYC - 1) : CNT_W'(PRES_LOW_STD - 1);
    assign rst_det = fast_q ? CNT_W'(RST_DET_OD) : CNT_W'(RST_DET_STD);

    // Byte taken only when offered and ready shown
    assign tx_push = TX_VALID_IN && TX_READY_OUT;
    assign tx_act = (tx_cnt_q != 4'h0);
    assign tx_take = !tx_act && fifo_out_valid && (state_q == S_IDLE) && line_s;
    assign slot_fall = (state_q == S_IDLE) && !line_s;
    assign sample_now = (state_q == S_WLOW) && (tmr_q == samp_last);
    assign rst_detect = (state_q == S_RECOVER) && !line_s && (low_cnt_q >= rst_det);
    assign long_rst = !line_s && (low_cnt_q >= CNT_W'(LONG_RST)) && (state_q == S_RSTLOW);
    assign rx_full = sample_now && (rx_cnt_q == 3'h7);
    assign rx_sh_next = {line_s, rx_sh_q[DATA_W-1:1]};

    // Slot engine
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE: begin
                if (slot_fall) begin
                    if (tx_act && !tx_sh_q[0]) begin
                        state_d = S_RDHOLD;
                    end else if (tx_act) begin
                        state_d = S_RECOVER;
                    end else begin
                        state_d = S_WLOW;
                    end
                end
            end
            S_WLOW: begin
                if (sample_now) begin
                    state_d = S_RECOVER;
                end
            end
            S_RDHOLD: begin
                if (tmr_q == hold_last) begin
                    state_d = S_RECOVER;
                end
            end
            S_RECOVER: begin
                if (rst_detect) begin
                    state_d = S_RSTLOW;
                end else if (line_s) begin
                    state_d = S_IDLE;
                end
            end
            S_RSTLOW: begin
                if (line_s) begin
                    state_d = S_PWAIT;
                end
            end
            S_PWAIT: begin
                if (tmr_q == pwait_last) begin
                    state_d = S_PLOW;
                end
            end
            S_PLOW: begin
                if (tmr_q == plow_last) begin
                    state_d = S_RECOVER;
                end
            end
        endcase
    end

    assign tmr_d = (state_d != state_q) ? '0 : tmr_q + 1'b1;
    assign low_cnt_d = (line_s || state_q == S_PLOW) ? '0 :
                       (low_cnt_q == '1) ? low_cnt_q : low_cnt_q + 1'b1;
    assign fast_d = FAST_SET_IN ? 1'b1 : (long_rst ? 1'b0 : fast_q);

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            state_q <= S_IDLE;
            tmr_q <= '0;
            low_cnt_q <= '0;
            fast_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            tmr_q <= tmr_d;
            low_cnt_q <= low_cnt_d;
            fast_q <= fast_d;
            oe_q <= (state_d == S_RDHOLD) || (state_d == S_PLOW);
        end
    end

    // Transmit shifter, fed from the FIFO
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            tx_sh_q <= '0;
            tx_cnt_q <= 4'h0;
        end else if (rst_detect) begin
            tx_cnt_q <= 4'h0;
        end else if (tx_take) begin
            tx_sh_q <= fifo_out_data;
            tx_cnt_q <= 4'h8;
        end else if (slot_fall && tx_act) begin
            tx_sh_q <= {1'b0, tx_sh_q[DATA_W-1:1]};
            tx_cnt_q <= tx_cnt_q - 4'h1;
        end
    end

    // Receive shifter for write slots
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            rx_sh_q <= '0;
            rx_cnt_q <= 3'h0;
            rx_byte_q <= '0;
            rx_valid_q <= 1'b0;
            rst_seen_q <= 1'b0;
        end else begin
            rx_valid_q <= rx_full;
            rst_seen_q <= rst_detect;
            if (rst_detect) begin
                rx_cnt_q <= 3'h0;
            end else if (sample_now) begin
                rx_sh_q <= rx_sh_next;
                rx_cnt_q <= rx_cnt_q + 3'h1;
            end
            if (rx_full) begin
                rx_byte_q <= rx_sh_next;
            end
        end
    end

    // Helper for driven-low duration checks
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            drive_len_q <= '0;
        end else if (oe_q) begin
            drive_len_q <= drive_len_q + 1'b1;
        end else begin
            drive_len_q <= '0;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_B_IN) begin
            TX_READY_OUT <= 1'b0;
        end else begin
            TX_READY_OUT <= fifo_in_ready && !(TX_VALID_IN && TX_READY_OUT);
        end
    end

    assign DQ_OUT = 1'b0;
    assign DQ_OE_OUT = oe_q;
    assign RX_BYTE_OUT = rx_byte_q;
    assign RX_VALID_OUT = rx_valid_q;
    assign RESET_SEEN_OUT = rst_seen_q;
    assign FAST_SPEED_FLAG_OUT = fast_q;

    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!RST_B_IN);

    AST_DRIVE_ONLY_LOW: assert property (DQ_OE_OUT |-> (DQ_OUT == 1'b0))
        else $error("Line driven to a high level");
    AST_NO_SLOT_START: assert property ($rose(DQ_OE_OUT) |-> (state_q == S_RDHOLD || state_q == S_PLOW))
        else $error("Device pulled line low outside presence or read");
    AST_PRES_QUIET: assert property ((state_q == S_PWAIT) |-> !DQ_OE_OUT)
        else $error("Line driven during presence wait");
    AST_PRES_LOW_STD: assert property ((state_q == S_PLOW && !fast_q) |-> (drive_len_q < CNT_W'(PRES_LOW_STD)))
        else $error("Standard presence low too long");
    AST_PRES_LOW_FAST: assert property ((state_q == S_PLOW && fast_q) |-> (drive_len_q < CNT_W'(PRES_LOW_OD_CYC)))
        else $error("Fast presence low too long");
    AST_RESET_ANSWER: assert property ($rose(RESET_SEEN_OUT) |-> (state_q == S_RSTLOW) && !DQ_OE_OUT)
        else $error("Reset not followed by presence sequence");
    AST_SAMPLE_POINT: assert property (sample_now |-> (tmr_q == samp_last) && $past(state_q) == S_WLOW)
        else $error("Write sample off its internal delay");
    AST_LSB_FIRST: assert property (rx_full |=> RX_VALID_OUT && (RX_BYTE_OUT[7] == $past(line_s)))
        else $error("Last received bit not in the top position");
    AST_LONG_RESET: assert property ((long_rst && !FAST_SET_IN) |=> !FAST_SPEED_FLAG_OUT)
        else $error("Long reset did not return to standard speed");
    AST_READ_HOLD: assert property ((state_q == S_RDHOLD) |-> (drive_len_q <= hold_last))
        else $error("Read zero held too long");
    AST_PRES_AFTER_WAIT: assert property (($rose(DQ_OE_OUT) && state_q == S_PLOW) |-> $past(state_q) == S_PWAIT)
        else $error("Presence low not preceded by presence wait");
    AST_READ_ONE_FREE: assert property ((slot_fall && tx_act && tx_sh_q[0]) |=> !DQ_OE_OUT)
        else $error("Line pulled low for a read one");
    AST_READ_ZERO_PULL: assert property ((slot_fall && tx_act && !tx_sh_q[0]) |=> DQ_OE_OUT)
        else $error("Line not pulled low for a read zero");
    AST_FAST_ENTER: assert property (FAST_SET_IN |=> FAST_SPEED_FLAG_OUT)
        else $error("Fast speed not entered when set");
    AST_STD_UNLESS_SET: assert property ((!FAST_SPEED_FLAG_OUT && !FAST_SET_IN) |=> !FAST_SPEED_FLAG_OUT)
        else $error("Fast speed entered without being set");
    AST_RESET_DISCARD: assert property (rst_detect |=> (rx_cnt_q == 3'h0))
        else $error("Partial byte kept across reset");
endmodule

// ### bench/swid_master.sv
`timescale 1ns/1ps
module swid_master (
    input wire logic clk_in,
    input wire logic line_in,
    output logic oe_out
);
    // Pull low only, never drive high
    initial oe_out = 1'b0;

    task automatic low_for(input int n);
        @(posedge clk_in);
        oe_out <= 1'b1;
        repeat (n) @(posedge clk_in);
        oe_out <= 1'b0;
    endtask

    // Line left released high between slots
    task automatic settle(input bit fast);
        int i;
        for (i = 0; i < 8000 && line_in !== 1'b1; i++) @(posedge clk_in);
        repeat (fast ? 40 : 100) @(posedge clk_in);
    endtask

    // Slot kept open past the device's write sample point
    task automatic write_bit(input bit b, input bit fast);
        low_for(b ? (fast ? 150 : 1000) : (fast ? 800 : 7600));
        if (b) repeat (fast ? 300 : 2900) @(posedge clk_in);
        settle(fast);
    endtask

    task automatic read_bit(input bit fast, output logic b);
        low_for(fast ? 130 : 650);
        repeat (fast ? 70 : 550) @(posedge clk_in);
        b = line_in;
        settle(fast);
    endtask

    task automatic write_byte(input logic [7:0] d, input bit fast);
        for (int i = 0; i < 8; i++) write_bit(d[i], fast);
    endtask

    task automatic read_byte(input bit fast, output logic [7:0] d);
        for (int i = 0; i < 8; i++) read_bit(fast, d[i]);
    endtask

    // Presence looked for before and inside its window
    task automatic reset_pulse(input int n, input bit fast, output logic pre, output logic pres);
        low_for(n);
        repeat (fast ? 200 : 3000) @(posedge clk_in);
        pre = line_in;
        repeat (fast ? 600 : 4600) @(posedge clk_in);
        pres = line_in;
        settle(fast);
    endtask
endmodule

// ### bench/tb_swid_slave.sv
`timescale 1ns/1ps
module tb_swid_slave;
    import swid_pkg::*;
    logic clk;
    logic rst_b;
    logic fast_set;
    logic tx_valid;
    logic [DATA_W-1:0] tx_data;
    logic [DATA_W-1:0] rx_byte;
    logic [DATA_W-1:0] rx_last;
    logic dev_oe;
    logic m_oe;
    logic line;
    logic tx_ready;
    logic rx_valid;
    logic rst_seen;
    logic fast_flag;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_rst = 0;
    int n_rx = 0;

    assign line = !(dev_oe | m_oe);

    swid_slave #(.RST_DET_STD(8000), .RST_DET_OD(900), .LONG_RST(8500), .PRES_LOW_STD(7500)) i_dut (
        .CORE_CLK_IN(clk), .RST_B_IN(rst_b), .DQ_IN(line), .DQ_OUT(), .DQ_OE_OUT(dev_oe),
        .FAST_SET_IN(fast_set), .TX_VALID_IN(tx_valid), .TX_DATA_IN(tx_data), .TX_READY_OUT(tx_ready),
        .RX_BYTE_OUT(rx_byte), .RX_VALID_OUT(rx_valid), .RESET_SEEN_OUT(rst_seen),
        .FAST_SPEED_FLAG_OUT(fast_flag)
    );

    swid_master i_master (.clk_in(clk), .line_in(line), .oe_out(m_oe));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        if (rst_seen === 1'b1) n_rst <= n_rst + 1;
        if (rx_valid === 1'b1) begin
            n_rx <= n_rx + 1;
            rx_last <= rx_byte;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic push(input logic [7:0] d, output bit ok);
        ok = 1'b0;
        tx_valid <= 1'b1;
        tx_data <= d;
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge clk);
            ok = (tx_ready === 1'b1);
        end
        tx_valid <= 1'b0;
        @(posedge clk);
    endtask

    task automatic t_reset_std;
        logic pre;
        logic pres;
        int r0;
        r0 = n_rst;
        i_master.reset_pulse(8200, 1'b0, pre, pres);
        chk(pre, 1);
        chk(pres, 0);
        chk(16'(n_rst - r0), 1);
        chk(fast_flag, 0);
    endtask

    task automatic t_write_std;
        int r0;
        int x0;
        r0 = n_rst;
        x0 = n_rx;
        i_master.write_byte(8'hEF, 1'b0);
        chk(rx_last, 8'hEF);
        chk(16'(n_rx - x0), 1);
        chk(16'(n_rst - r0), 0);
    endtask

    task automatic t_fast;
        logic pre;
        logic pres;
        fast_set <= 1'b1;
        @(posedge clk);
        fast_set <= 1'b0;
        repeat (2) @(posedge clk);
        chk(fast_flag, 1);
        i_master.reset_pulse(1000, 1'b1, pre, pres);
        chk(pre, 1);
        chk(pres, 0);
        chk(fast_flag, 1);
        i_master.write_byte(8'h3C, 1'b1);
        chk(rx_last, 8'h3C);
    endtask

    task automatic t_fifo_read;
        logic [7:0] q[$];
        logic [7:0] d;
        bit ok;
        ok = 1'b1;
        for (int k = 0; ok && k < 12; k++) begin
            d = 8'(8'h5A + k * 43);
            push(d, ok);
            if (ok) q.push_back(d);
        end
        chk(tx_ready, 0); // buffer refuses when full
        chk(16'(q.size() >= FIFO_DEPTH), 1); // buffer depth
        while (q.size() > 0) begin
            i_master.read_byte(1'b1, d);
            chk(d, q.pop_front());
        end
        chk(tx_ready, 1); // buffer drained
    endtask

    task automatic t_long_reset;
        logic pre;
        logic pres;
        i_master.reset_pulse(8600, 1'b0, pre, pres);
        chk(fast_flag, 0);
        chk(pre, 1);
        chk(pres, 0);
    endtask

    initial begin
        rst_b = 1'b0;
        fast_set = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        rx_last = 8'h00;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        chk(dev_oe, 0);
        chk(tx_ready, 1); // ready after reset
        repeat (100) @(posedge clk);
        t_reset_std();
        t_write_std();
        t_fast();
        t_fifo_read();
        t_long_reset();
        conclude();
    end

    initial begin
        #(8 * 150000);
        n_mismatch++;
        conclude();
    end
endmodule
